// ==== hw/dmhcp_port.sv ====
// Dual mode (four-wire select / two-wire) host control port slave.
// Assumes registers outside answer reg_rdata_in combinationally from reg_addr_out,
// and that the host keeps select high for at least eight system clocks between frames.
//
// Contract
// - Select falling after reset picks four-wire mode.
// - Four-wire: sample on rise, drive on fall.
// - Four-wire chip address 0010000, then direction bit.
// - Pointer byte, then data bytes, MSB first.
// - Output stays high impedance during writes.
// - Pointer steps per data byte only if enabled.
// - Read drives MSB on next falling edge.
// - Two-wire address is 0010 plus three straps.
// - Two-wire write: pointer byte, then data bytes.
// - Two-wire read returns pointed registers, stepping only if enabled.
// - Device acks received bytes; host acks sent.
// - Link fully asynchronous to system clock.
// - Alert pin: active high, low or open drain.
// - Masked sources never reach the alert pin.
// - Each source flags on rise, fall or level.
// - Pointer MSB enables stepping, reset disabled.
// - Polarity codes 00 high, 01 low, 10 drain.
`timescale 1ns/10ps
module dmhcp_port
   import dmhcp_pkg::*;
#(
   parameter int NSRC = 2
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic control_bit_clock_in,
   input wire logic addr_bit0_or_select_in,
   input wire logic addr_strap_bit1_in,
   input wire logic addr_strap_bit2_in,
   input wire logic control_serial_in,
   output logic control_serial_out,
   output logic control_serial_oe_out,
   output logic spi_mode_out,
   output logic [7:0] register_pointer_out,
   output logic [6:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [7:0] reg_rdata_in,
   input wire logic [1:0] alert_pin_polarity_field_in,
   input wire logic [NSRC-1:0] irq_src_in,
   input wire logic [NSRC-1:0] irq_mask_in,
   input wire logic [2*NSRC-1:0] irq_mode_in,
   input wire logic [NSRC-1:0] irq_clear_in,
   output logic [NSRC-1:0] irq_status_out,
   output logic host_alert_out,
   output logic host_alert_oe_out
);

   typedef struct packed {
      logic [2:0] settle;
      logic armed;
      logic strap;
      logic spi;
      logic [DMHCP_SY_W-1:0] s0;
      logic [DMHCP_SY_W-1:0] s1;
      logic [DMHCP_SY_W-1:0] s2;
      logic [DMHCP_SY_W-1:0] flt;
      logic [1:0] tref;
      logic [7:0] ptr;
      logic [6:0] addr;
      logic [7:0] rdq;
      logic [1:0] rel;
      logic wr;
      logic rd;
      logic [7:0] wdata;
      dmhcp_i2c_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [1:0] bno;
      logic rw;
      logic hacked;
      logic sda_oe;
      logic [NSRC-1:0] srcq;
      logic [NSRC-1:0] stat;
      logic act;
      logic alert;
      logic alert_oe;
   } dmhcp_sys_t;

   function automatic logic [7:0] dmhcp_step(input logic [7:0] p);
      dmhcp_step = p[DMHCP_PTR_STEP_BIT] ? {p[7], p[6:0] + 7'h1} : p;
   endfunction

   // ************************************************************
   // Link domain, clocked by the host's bit clock
   // ************************************************************
   // The select pin itself clears the link side, so nothing depends on link
   // clock edges outside a frame.
   logic lnk_rst_n;
   dmhcp_lnk_t l_q, l_d;
   dmhcp_sys_t s_q, s_d;
   logic spi_out_q, spi_oe_q;

   assign lnk_rst_n = resetn_in & ~addr_bit0_or_select_in;

   always_comb begin
      l_d = l_q;
      l_d.busy = 1'b1;
      l_d.cnt = l_q.cnt + 3'h1;
      l_d.sh = {l_q.sh[5:0], control_serial_in};
      if (l_q.bno == 2'h0) begin
         if (l_q.cnt == 3'h7) begin
            l_d.bno = 2'h1;
            l_d.match = (l_q.sh == DMHCP_SPI_CHIP_ADDR);
            l_d.rw = control_serial_in;
            if (l_d.match && control_serial_in) begin
               l_d.tx = s_q.rdq;
               l_d.rd_act = 1'b1;
            end
         end
      end else if (l_q.match) begin
         if (l_q.rw) begin
            if (l_q.cnt == 3'h0) begin
               l_d.cons_tog = ~l_q.cons_tog;
            end
            l_d.tx = (l_q.cnt == 3'h7) ? s_q.rdq : {l_q.tx[6:0], 1'b0};
         end else if (l_q.cnt == 3'h7) begin
            l_d.wr_byte = {l_q.sh, control_serial_in};
            l_d.wr_isptr = (l_q.bno == 2'h1);
            l_d.wr_tog = ~l_q.wr_tog;
            l_d.bno = 2'h2;
         end
      end
   end

   always_ff @(posedge control_bit_clock_in or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // Data leaves on the falling edge so the host samples it stable on the rise.
   always_ff @(negedge control_bit_clock_in or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         spi_out_q <= 1'b0;
         spi_oe_q <= 1'b0;
      end else begin
         spi_out_q <= l_q.tx[7];
         spi_oe_q <= l_q.rd_act;
      end
   end

   // ************************************************************
   // System domain: mode, pointer, two-wire engine, interrupts
   // ************************************************************
   logic [DMHCP_SY_W-1:0] chg;
   logic scl_r, scl_f, start_c, stop_c, load, wreq;
   logic [7:0] wbyte;
   logic [NSRC-1:0] hit;

   always_comb begin
      s_d = s_q;
      load = 1'b0;
      wreq = 1'b0;
      wbyte = s_q.sh;
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      // Link toggles and pins all cross through three stages; a lane changes
      // only once the second and third stages agree.
      s_d.s0 = {addr_strap_bit2_in, addr_strap_bit1_in, l_q.cons_tog, l_q.wr_tog,
                l_q.busy, control_serial_in, control_bit_clock_in, addr_bit0_or_select_in};
      s_d.s1 = s_q.s0;
      s_d.s2 = s_q.s1;
      s_d.flt = (s_q.s1 & s_q.s2) | (s_q.flt & (s_q.s1 | s_q.s2));
      chg = s_d.flt ^ s_q.flt;
      scl_r = chg[DMHCP_SY_SCL] & s_d.flt[DMHCP_SY_SCL];
      scl_f = chg[DMHCP_SY_SCL] & ~s_d.flt[DMHCP_SY_SCL];
      start_c = chg[DMHCP_SY_SDA] & ~s_d.flt[DMHCP_SY_SDA] & s_q.flt[DMHCP_SY_SCL]
                & s_d.flt[DMHCP_SY_SCL];
      stop_c = chg[DMHCP_SY_SDA] & s_d.flt[DMHCP_SY_SDA] & s_q.flt[DMHCP_SY_SCL]
               & s_d.flt[DMHCP_SY_SCL];
      if (!s_q.armed) begin
         s_d.settle = s_q.settle + 3'h1;
         if (s_q.settle == DMHCP_SETTLE_CYCLES) begin
            s_d.armed = 1'b1;
            s_d.strap = s_q.flt[DMHCP_SY_CS];
         end
      end else if (!s_q.spi && chg[DMHCP_SY_CS] && !s_d.flt[DMHCP_SY_CS]) begin
         s_d.spi = 1'b1;
         s_d.st = DMHCP_I_IDLE;
         s_d.sda_oe = 1'b0;
      end
      // A frame end clears the link toggles, which would look like one more byte.
      // Events are taken one cycle late and only while the link is still busy,
      // so a lane that settles a cycle apart from busy cannot fake a byte.
      s_d.tref = {s_q.flt[DMHCP_SY_CONS], s_q.flt[DMHCP_SY_WR]};
      if (s_q.spi) begin
         if ((s_q.flt[DMHCP_SY_WR] ^ s_q.tref[0]) & s_d.flt[DMHCP_SY_BUSY]) begin
            if (l_q.wr_isptr) begin
               s_d.ptr = l_q.wr_byte;
            end else begin
               wreq = 1'b1;
               wbyte = l_q.wr_byte;
            end
         end
         if ((s_q.flt[DMHCP_SY_CONS] ^ s_q.tref[1]) & s_d.flt[DMHCP_SY_BUSY]) begin
            s_d.rd = 1'b1;
            s_d.ptr = dmhcp_step(s_q.ptr);
         end
      end else if (s_q.armed) begin
         unique case (s_q.st)
            DMHCP_I_IDLE: begin
            end
            DMHCP_I_RX: begin
               if (scl_r) begin
                  s_d.sh = {s_q.sh[6:0], s_q.flt[DMHCP_SY_SDA]};
                  s_d.cnt = s_q.cnt + 4'h1;
               end
               if (scl_f && s_q.cnt == DMHCP_BITS_PER_BYTE) begin
                  s_d.st = DMHCP_I_ACK;
                  s_d.sda_oe = 1'b1;
                  if (s_q.bno == 2'h0) begin
                     s_d.bno = 2'h1;
                     s_d.rw = s_q.sh[0];
                     if (s_q.sh[7:1] != {DMHCP_I2C_ADDR_HI, s_q.flt[DMHCP_SY_S2],
                                         s_q.flt[DMHCP_SY_S1], s_q.strap}) begin
                        s_d.st = DMHCP_I_IDLE;
                        s_d.sda_oe = 1'b0;
                     end
                  end else if (s_q.bno == 2'h1) begin
                     s_d.ptr = s_q.sh;
                     s_d.bno = 2'h2;
                  end else begin
                     wreq = 1'b1;
                  end
               end
            end
            DMHCP_I_ACK: begin
               if (scl_f) begin
                  s_d.sda_oe = 1'b0;
                  s_d.cnt = 4'h0;
                  s_d.st = DMHCP_I_RX;
                  load = s_q.rw;
               end
            end
            DMHCP_I_TX: begin
               if (scl_f) begin
                  if (s_q.cnt == 4'h7) begin
                     s_d.st = DMHCP_I_HACK;
                     s_d.sda_oe = 1'b0;
                  end else begin
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                     s_d.sda_oe = ~s_q.sh[6];
                     s_d.cnt = s_q.cnt + 4'h1;
                  end
               end
            end
            DMHCP_I_HACK: begin
               if (scl_r) begin
                  s_d.hacked = ~s_q.flt[DMHCP_SY_SDA];
               end
               if (scl_f) begin
                  load = s_q.hacked;
                  s_d.st = DMHCP_I_IDLE;
               end
            end
         endcase
         if (load) begin
            s_d.sh = s_q.rdq;
            s_d.sda_oe = ~s_q.rdq[7];
            s_d.cnt = 4'h0;
            s_d.rd = 1'b1;
            s_d.ptr = dmhcp_step(s_q.ptr);
            s_d.st = DMHCP_I_TX;
         end
         if (start_c) begin
            s_d.st = DMHCP_I_RX;
            s_d.cnt = 4'h0;
            s_d.bno = 2'h0;
            s_d.sda_oe = 1'b0;
         end else if (stop_c) begin
            s_d.st = DMHCP_I_IDLE;
            s_d.sda_oe = 1'b0;
         end
      end
      if (wreq) begin
         s_d.wr = 1'b1;
         s_d.wdata = wbyte;
         s_d.ptr = dmhcp_step(s_q.ptr);
      end
      s_d.addr = wreq ? s_q.ptr[6:0] : s_d.ptr[6:0];
      // The read word is frozen while a four-wire frame may be copying it; it
      // is only refreshed after the pointer moves or a data byte is written.
      s_d.rel = {s_q.rel[0], wreq | (s_d.ptr != s_q.ptr)};
      if (!(s_q.spi && s_q.flt[DMHCP_SY_BUSY]) || (s_q.rel != 2'h0)) begin
         s_d.rdq = reg_rdata_in;
      end
      // Interrupt sources are on this clock; set wins over clear.
      s_d.srcq = irq_src_in;
      for (int i = 0; i < NSRC; i++) begin
         unique case (irq_mode_in[2*i +: 2])
            DMHCP_IRQ_RISE: hit[i] = irq_src_in[i] & ~s_q.srcq[i];
            DMHCP_IRQ_FALL: hit[i] = ~irq_src_in[i] & s_q.srcq[i];
            default: hit[i] = irq_src_in[i];
         endcase
      end
      s_d.stat = (s_q.stat & ~irq_clear_in) | hit;
      s_d.act = |(s_d.stat & irq_mask_in);
      unique case (alert_pin_polarity_field_in)
         DMHCP_POL_LOW: begin
            s_d.alert = ~s_d.act;
            s_d.alert_oe = 1'b1;
         end
         DMHCP_POL_OD: begin
            s_d.alert = 1'b0;
            s_d.alert_oe = s_d.act;
         end
         default: begin
            s_d.alert = s_d.act;
            s_d.alert_oe = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_q <= '0;
         s_q.ptr <= DMHCP_PTR_RESET;
         s_q.st <= DMHCP_I_IDLE;
         s_q.alert_oe <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign control_serial_out = s_q.spi ? spi_out_q : 1'b0;
   assign control_serial_oe_out = s_q.spi ? spi_oe_q : s_q.sda_oe;
   assign spi_mode_out = s_q.spi;
   assign register_pointer_out = s_q.ptr;
   assign reg_addr_out = s_q.addr;
   assign reg_wdata_out = s_q.wdata;
   assign reg_wr_out = s_q.wr;
   assign reg_rd_out = s_q.rd;
   assign irq_status_out = s_q.stat;
   assign host_alert_out = s_q.alert;
   assign host_alert_oe_out = s_q.alert_oe;

   // ************************************************************
   // Checks
   // ************************************************************
   a_spi_wr_hiz: assert property (@(posedge control_bit_clock_in) disable iff (!lnk_rst_n)
      (l_q.bno != 2'h0 && !l_q.rw) |-> !spi_oe_q) else $error("driven in write");
   a_spi_rd_msb: assert property (@(posedge control_bit_clock_in) disable iff (!lnk_rst_n)
      $rose(l_q.rd_act) |-> spi_oe_q && spi_out_q == l_q.tx[7])
      else $error("read MSB not driven");
   a_ptr_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (s_q.wr && !s_q.ptr[7]) |-> s_q.ptr[6:0] == s_q.addr) else $error("pointer moved");
   a_ptr_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (s_q.wr && s_q.ptr[7]) |-> s_q.ptr[6:0] == s_q.addr + 7'h1)
      else $error("pointer did not step");
   a_mask_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      s_q.act |-> (s_q.stat & $past(irq_mask_in)) != '0) else $error("masked alert");
   a_level_flag: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (irq_mode_in[1:0] == DMHCP_IRQ_LEVEL && irq_src_in[0]) |=> s_q.stat[0])
      else $error("level source not flagged");
   a_od_low: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (s_q.act && $past(alert_pin_polarity_field_in) == DMHCP_POL_OD)
      |-> host_alert_oe_out && !host_alert_out) else $error("drain alert wrong");
   a_mode_lock: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      s_q.spi |=> s_q.spi) else $error("mode left four-wire");
   a_ack_drive: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (!s_q.spi && s_q.st == DMHCP_I_ACK) |-> control_serial_oe_out && !control_serial_out)
      else $error("ack not driven");

endmodule

// ==== hw/dmhcp_pkg.sv ====
// Constants, states and state layouts of the dual mode host control port.
// Assumes one system clock and a link clock made by the host.
package dmhcp_pkg;

   // ************************************************************
   // Addresses and pointer layout
   // ************************************************************
   localparam logic [6:0] DMHCP_SPI_CHIP_ADDR = 7'h10;
   localparam logic [3:0] DMHCP_I2C_ADDR_HI = 4'h2;
   localparam logic [7:0] DMHCP_PTR_RESET = 8'h00;
   localparam int DMHCP_PTR_STEP_BIT = 7;

   // ************************************************************
   // Alert pin and interrupt source modes
   // ************************************************************
   localparam logic [1:0] DMHCP_POL_HIGH = 2'h0;
   localparam logic [1:0] DMHCP_POL_LOW = 2'h1;
   localparam logic [1:0] DMHCP_POL_OD = 2'h2;
   localparam logic [1:0] DMHCP_IRQ_RISE = 2'h0;
   localparam logic [1:0] DMHCP_IRQ_FALL = 2'h1;
   localparam logic [1:0] DMHCP_IRQ_LEVEL = 2'h2;

   // ************************************************************
   // Synchroniser lanes and timing
   // ************************************************************
   localparam int DMHCP_SY_CS = 0;
   localparam int DMHCP_SY_SCL = 1;
   localparam int DMHCP_SY_SDA = 2;
   localparam int DMHCP_SY_BUSY = 3;
   localparam int DMHCP_SY_WR = 4;
   localparam int DMHCP_SY_CONS = 5;
   localparam int DMHCP_SY_S1 = 6;
   localparam int DMHCP_SY_S2 = 7;
   localparam int DMHCP_SY_W = 8;
   localparam logic [2:0] DMHCP_SETTLE_CYCLES = 3'h4;
   localparam logic [3:0] DMHCP_BITS_PER_BYTE = 4'h8;

   typedef enum logic [4:0] {
      DMHCP_I_IDLE = 5'h01,
      DMHCP_I_RX = 5'h02,
      DMHCP_I_ACK = 5'h04,
      DMHCP_I_TX = 5'h08,
      DMHCP_I_HACK = 5'h10
   } dmhcp_i2c_st_t;

   typedef struct packed {
      logic busy;
      logic [2:0] cnt;
      logic [1:0] bno;
      logic [6:0] sh;
      logic match;
      logic rw;
      logic wr_tog;
      logic wr_isptr;
      logic [7:0] wr_byte;
      logic cons_tog;
      logic [7:0] tx;
      logic rd_act;
   } dmhcp_lnk_t;

endpackage

// ==== sim/dmhcp_host_model.sv ====
// Host master model: makes the link clock, select and data for the port.
// Assumes the bench resolves the data wire and hands it back on rx_in.
`timescale 1ns/10ps
module dmhcp_host_model (
   input wire logic rx_in,
   output logic bclk_out,
   output logic sel_out,
   output logic data_out
);
   logic lclk;
   int h;
   // ************************************************************
   // Link clock, free running; the bit clock stands still between frames
   // ************************************************************
   initial begin
      lclk = 1'b0;
      #3.3;
      forever #6 lclk = ~lclk;
   end
   initial begin
      bclk_out = 1'b1;
      sel_out = 1'b1;
      data_out = 1'b1;
      h = 100;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge lclk);
   endtask
   // ************************************************************
   // Bit and byte transfers
   // ************************************************************
   // Data moves half way into the low phase, so it never races a clock edge.
   task automatic bit_x(input logic b, output logic r);
      tk(h / 2);
      data_out <= b;
      tk(h / 2);
      bclk_out <= 1'b1;
      tk(h);
      r = rx_in;
      bclk_out <= 1'b0;
   endtask
   task automatic xfer(input logic i2c, input logic [7:0] tx, input logic ack_in,
         output logic [7:0] rx, output logic ack_out);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], r);
         rx[i] = r;
      end
      ack_out = 1'b1;
      if (i2c) begin
         bit_x(ack_in, ack_out);
      end
   endtask
   task automatic start(input logic i2c);
      if (i2c) begin
         data_out <= 1'b0;
         tk(h);
         bclk_out <= 1'b0;
      end else begin
         h = 28;
         bclk_out <= 1'b0;
         tk(h);
         sel_out <= 1'b0;
         tk(h);
      end
   endtask
   // Select stays high long enough for the port to see the frame end.
   task automatic stop(input logic i2c);
      if (i2c) begin
         tk(h / 2);
         data_out <= 1'b0;
         tk(h / 2);
         bclk_out <= 1'b1;
         tk(h);
         data_out <= 1'b1;
      end else begin
         tk(h);
         sel_out <= 1'b1;
      end
      tk(2 * h);
   endtask
endmodule

// ==== sim/dual_mode_host_control_port_bench.sv ====
// Self-checking bench of the dual mode host control port.
// Assumes the host model drives the link; the bench holds the register file.
`timescale 1ns/10ps
module dual_mode_host_control_port_bench
   import dmhcp_pkg::*;
;
   logic clk_sys_in, resetn_in, spi_sel, filler, bclk, sel, hdata, hrx, din;
   logic oe, sout, spi_mode, wr, rd, alert, alert_oe, oe_seen;
   logic [7:0] ptr, wdata, rdata;
   logic [6:0] raddr;
   logic [1:0] pol, irq_src, irq_mask, irq_clear, irq_status;
   logic [3:0] irq_mode, acks;
   logic [7:0] regs [0:127];
   logic [7:0] rxb [4];
   int fails, samples_checked, wr_count, rd_count, cycles, n;
   // Data line has a pull-up; the unselected output wire toggles.
   assign din = spi_sel ? hdata : (hdata & ~oe);
   assign hrx = spi_sel ? (oe ? sout : filler) : (hdata & ~oe);
   assign rdata = regs[raddr];
   dmhcp_host_model host (.rx_in(hrx), .bclk_out(bclk), .sel_out(sel), .data_out(hdata));
   dmhcp_port #(.NSRC(2)) dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .control_bit_clock_in(bclk), .addr_bit0_or_select_in(sel),
      .addr_strap_bit1_in(1'b0), .addr_strap_bit2_in(1'b1), .control_serial_in(din),
      .control_serial_out(sout), .control_serial_oe_out(oe), .spi_mode_out(spi_mode),
      .register_pointer_out(ptr), .reg_addr_out(raddr), .reg_wdata_out(wdata),
      .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata),
      .alert_pin_polarity_field_in(pol), .irq_src_in(irq_src), .irq_mask_in(irq_mask),
      .irq_mode_in(irq_mode), .irq_clear_in(irq_clear), .irq_status_out(irq_status),
      .host_alert_out(alert), .host_alert_oe_out(alert_oe));
   // ************************************************************
   // Clock, register file and watchdog
   // ************************************************************
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      filler <= ~filler;
      cycles++;
      if (wr === 1'b1) begin
         regs[raddr] <= wdata;
         wr_count++;
      end
      if (rd === 1'b1) begin
         rd_count++;
      end
      if (oe === 1'b1) begin
         oe_seen <= 1'b1;
      end
      if (cycles == 20000) begin
         fails++;
         print_verdict();
      end
   end
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk_sys_in);
      @(posedge clk_sys_in);
   endtask
   task automatic do_reset();
      @(posedge clk_sys_in);
      resetn_in <= 1'b0;
      tick(4);
      resetn_in <= 1'b1;
      tick(16);
   endtask
   // Address and write bytes first, then read bytes; in two-wire the last read is refused.
   task automatic frame(input logic i2c, input int nw, input int nr, input logic [7:0] b0,
         input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
      logic [7:0] tx [4];
      tx = '{b0, b1, b2, b3};
      oe_seen <= 1'b0;
      host.start(i2c);
      for (int i = 0; i < nw; i++) begin
         host.xfer(i2c, tx[i], 1'b1, rxb[i], acks[i]);
      end
      for (int i = 0; i < nr; i++) begin
         host.xfer(i2c, 8'hff, (i == nr - 1), rxb[i], acks[i]);
      end
      host.stop(i2c);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      check({spi_mode, oe, alert, alert_oe}, 8'h1);
      check(ptr, DMHCP_PTR_RESET);
      $display("test reset done");
   endtask
   task automatic t_i2c_write();
      frame(1'b1, 1, 0, 8'h2c, 8'h0, 8'h0, 8'h0);
      check({acks[0], oe_seen}, 8'h2);
      check(ptr, 8'h00);
      frame(1'b1, 4, 0, 8'h2a, 8'h85, 8'ha1, 8'hb2);
      check(acks, 4'h0);
      check(regs[5], 8'ha1);
      check(regs[6], 8'hb2);
      check(ptr, 8'h87);
      $display("test i2c write done");
   endtask
   task automatic t_i2c_read();
      frame(1'b1, 2, 0, 8'h2a, 8'h05, 8'h0, 8'h0);
      n = rd_count;
      frame(1'b1, 1, 2, 8'h2b, 8'h0, 8'h0, 8'h0);
      check(rxb[0], 8'ha1);
      check(rxb[1], 8'ha1);
      check(ptr, 8'h05);
      check(8'(rd_count - n), 8'h2);
      $display("test i2c read done");
   endtask
   task automatic t_irq();
      irq_mask <= 2'h1;
      irq_mode <= 4'h8;
      irq_src <= 2'h2;
      tick(3);
      check(alert, 1'b0);
      irq_src <= 2'h3;
      tick(3);
      check({irq_status[0], alert}, 2'h3);
      irq_clear <= 2'h1;
      tick(3);
      irq_clear <= 2'h0;
      check(irq_status[0], 1'b0);
      irq_mode <= 4'h9;
      irq_src <= 2'h2;
      tick(3);
      check(irq_status[0], 1'b1);
      pol <= DMHCP_POL_LOW;
      tick(3);
      check({alert, alert_oe}, 2'h1);
      pol <= DMHCP_POL_OD;
      tick(3);
      check({alert, alert_oe}, 2'h1);
      irq_clear <= 2'h1;
      tick(3);
      check({alert, alert_oe}, 2'h0);
      irq_mode <= 4'ha;
      irq_src <= 2'h3;
      tick(3);
      check(irq_status[0], 1'b1);
      irq_clear <= 2'h0;
      pol <= DMHCP_POL_HIGH;
      $display("test interrupts done");
   endtask
   task automatic t_spi_write();
      frame(1'b0, 3, 0, 8'h20, 8'h03, 8'h5a, 8'h0);
      check(regs[3], 8'h5a);
      check({spi_mode, oe_seen}, 8'h2);
      n = wr_count;
      frame(1'b0, 3, 0, 8'h24, 8'h7f, 8'h11, 8'h0);
      check(ptr, 8'h03);
      check(wr_count - n, 8'h0);
      check(oe_seen, 1'b0);
      $display("test spi write done");
   endtask
   task automatic t_spi_read();
      frame(1'b0, 2, 0, 8'h20, 8'h83, 8'h0, 8'h0);
      n = rd_count;
      frame(1'b0, 1, 2, 8'h21, 8'h0, 8'h0, 8'h0);
      check(rxb[0], 8'h5a);
      check(rxb[1], 8'h44);
      check(ptr, 8'h85);
      check(8'(rd_count - n), 8'h2);
      $display("test spi read done");
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Mode is sticky, so two-wire runs first and a second reset opens four-wire.
   initial begin
      resetn_in = 1'b0;
      spi_sel = 1'b0;
      filler = 1'b0;
      oe_seen = 1'b0;
      pol = DMHCP_POL_HIGH;
      irq_src = 2'h0;
      irq_mask = 2'h0;
      irq_mode = 4'h0;
      irq_clear = 2'h0;
      for (int i = 0; i < 128; i++) begin
         regs[i] = 8'h40 + 8'(i);
      end
      do_reset();
      t_reset();
      t_i2c_write();
      t_i2c_read();
      t_irq();
      do_reset();
      spi_sel <= 1'b1;
      t_spi_write();
      t_spi_read();
      print_verdict();
   end
endmodule
